/* File: hdl/oraex_pkg.sv */
// package of opcodes, field positions and reset values for the instruction executor
package oraex_pkg;
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int D_BIT = 7;
   // opcode field positions inside the instruction word
   localparam int OP_MSB = 13;
   localparam int OP_FILE_LSB = 8;
   localparam int OP_LITERAL_LSB = 10;
   localparam int OP_STORE_LSB = 7;
   localparam logic [5:0] OP_OR_WORK_WITH_FILE = 6'h04;
   localparam logic [5:0] OP_MOVE_FILE = 6'h08;
   localparam logic [3:0] OP_LOAD_LITERAL_HI = 4'hC;
   localparam logic [6:0] OP_STORE_WORK_HI = 7'h01;
   localparam logic [7:0] WORK_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'b0;
   typedef enum {oraex_op_none, oraex_op_or, oraex_op_move, oraex_op_literal, oraex_op_store} oraex_op_e;
endpackage

/* File: hdl/oraex_dec_if.sv */
// interface carrying decoded instruction fields from the decoder to the executor
`timescale 1ns/1ps
interface oraex_dec_if;
   oraex_pkg::oraex_op_e op;
   logic dest_file;
   logic [oraex_pkg::ADDR_W-1:0] addr;
   logic [oraex_pkg::DATA_W-1:0] literal;
   modport decoder (output op, output dest_file, output addr, output literal);
   modport executor (input op, input dest_file, input addr, input literal);
endinterface

/* File: hdl/oraex_decode.sv */
// combinational opcode decoder for the four instructions
`timescale 1ns/1ps
module oraex_decode (
   input wire logic [oraex_pkg::INSTR_W-1:0] instr_in,
   oraex_dec_if.decoder dec
);
   always_comb
   begin
      dec.addr = instr_in[oraex_pkg::ADDR_W-1:0];
      dec.literal = instr_in[oraex_pkg::DATA_W-1:0];
      dec.dest_file = instr_in[oraex_pkg::D_BIT];
      dec.op = oraex_pkg::oraex_op_none;
      if (instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_FILE_LSB] == oraex_pkg::OP_OR_WORK_WITH_FILE)
         dec.op = oraex_pkg::oraex_op_or;
      else if (instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_FILE_LSB] == oraex_pkg::OP_MOVE_FILE)
         dec.op = oraex_pkg::oraex_op_move;
      else if (instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_LITERAL_LSB] == oraex_pkg::OP_LOAD_LITERAL_HI)
         dec.op = oraex_pkg::oraex_op_literal;
      else if (instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_STORE_LSB] == oraex_pkg::OP_STORE_WORK_HI)
         dec.op = oraex_pkg::oraex_op_store;
   end
endmodule

/* File: hdl/oraex_core.sv */
// executor for or-with-file, move-file, load-literal and store-work instructions
`timescale 1ns/1ps
module oraex_core (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic instr_valid_in,
   input wire logic [oraex_pkg::INSTR_W-1:0] instr_in,
   input wire logic [oraex_pkg::DATA_W-1:0] file_rdata_in,
   output logic [oraex_pkg::ADDR_W-1:0] file_raddr_out,
   output logic file_we_out,
   output logic [oraex_pkg::ADDR_W-1:0] file_waddr_out,
   output logic [oraex_pkg::DATA_W-1:0] file_wdata_out,
   output logic [oraex_pkg::DATA_W-1:0] work_out,
   output logic zero_out,
   output logic handled_out
);
   typedef struct packed {
      logic [oraex_pkg::DATA_W-1:0] work;
      logic zero;
      logic we;
      logic [oraex_pkg::ADDR_W-1:0] waddr;
      logic [oraex_pkg::DATA_W-1:0] wdata;
      logic handled;
   } oraex_state_s;

   // the decoder slices assume this field layout; refuse any other
   if (oraex_pkg::INSTR_W != oraex_pkg::OP_MSB + 1)
   begin
      $error("instruction width does not match the opcode field");
   end
   if (oraex_pkg::D_BIT != oraex_pkg::ADDR_W)
   begin
      $error("destination bit must sit just above the address field");
   end
   if (oraex_pkg::DATA_W > oraex_pkg::OP_FILE_LSB)
   begin
      $error("literal field would overlap the opcode field");
   end
   if (oraex_pkg::ADDR_W > oraex_pkg::DATA_W)
   begin
      $error("address field wider than the data path");
   end

   oraex_state_s st;
   oraex_state_s next_st;
   oraex_dec_if dec ();
   logic [oraex_pkg::DATA_W-1:0] result;

   oraex_decode u_decode (
      .instr_in(instr_in),
      .dec(dec)
   );

   // read address is combinational so the operand arrives in the same cycle
   always_comb
   begin
      file_raddr_out = dec.addr;
   end

   always_comb
   begin
      next_st = st;
      next_st.we = 1'b0;
      next_st.handled = 1'b0;
      result = file_rdata_in;
      if (dec.op == oraex_pkg::oraex_op_or)
         result = st.work | file_rdata_in;
      if (instr_valid_in)
      begin
         case (dec.op)
            oraex_pkg::oraex_op_or, oraex_pkg::oraex_op_move:
            begin
               next_st.handled = 1'b1;
               next_st.zero = (result == '0);
               if (dec.dest_file)
               begin
                  next_st.we = 1'b1;
                  next_st.waddr = dec.addr;
                  next_st.wdata = result;
               end
               else
                  next_st.work = result;
            end
            oraex_pkg::oraex_op_literal:
            begin
               next_st.handled = 1'b1;
               next_st.work = dec.literal;
            end
            oraex_pkg::oraex_op_store:
            begin
               next_st.handled = 1'b1;
               next_st.we = 1'b1;
               next_st.waddr = dec.addr;
               next_st.wdata = st.work;
            end
            default:
            begin
               next_st.handled = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         st.work <= oraex_pkg::WORK_RESET;
         st.zero <= oraex_pkg::ZERO_RESET;
         st.we <= 1'b0;
         st.waddr <= '0;
         st.wdata <= '0;
         st.handled <= 1'b0;
      end
      else
         st <= next_st;
   end

   always_comb
   begin
      file_we_out = st.we;
      file_waddr_out = st.waddr;
      file_wdata_out = st.wdata;
      work_out = st.work;
      zero_out = st.zero;
      handled_out = st.handled;
   end

   // opcode matches in s_or_work through s_store are written from the encodings, not taken from the decoder
   sequence s_or_work;
      instr_valid_in && !instr_in[oraex_pkg::D_BIT]
      && instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_FILE_LSB] == oraex_pkg::OP_OR_WORK_WITH_FILE;
   endsequence
   sequence s_or_file;
      instr_valid_in && instr_in[oraex_pkg::D_BIT]
      && instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_FILE_LSB] == oraex_pkg::OP_OR_WORK_WITH_FILE;
   endsequence
   sequence s_move_any;
      instr_valid_in && instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_FILE_LSB] == oraex_pkg::OP_MOVE_FILE;
   endsequence
   sequence s_move_file;
      instr_valid_in && instr_in[oraex_pkg::D_BIT]
      && instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_FILE_LSB] == oraex_pkg::OP_MOVE_FILE;
   endsequence
   sequence s_move_work;
      instr_valid_in && !instr_in[oraex_pkg::D_BIT]
      && instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_FILE_LSB] == oraex_pkg::OP_MOVE_FILE;
   endsequence
   sequence s_literal;
      instr_valid_in && instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_LITERAL_LSB] == oraex_pkg::OP_LOAD_LITERAL_HI;
   endsequence
   sequence s_store;
      instr_valid_in && instr_in[oraex_pkg::OP_MSB:oraex_pkg::OP_STORE_LSB] == oraex_pkg::OP_STORE_WORK_HI;
   endsequence

   property p_or_result;
      @(posedge core_clk_in) disable iff (!resetn_in)
      s_or_work |=> work_out == ($past(work_out) | $past(file_rdata_in)) && !file_we_out;
   endproperty
   or_to_work_a: assert property (p_or_result) else $error("or result wrong");

   or_to_file_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_or_file |=> file_we_out && file_wdata_out == ($past(work_out) | $past(file_rdata_in))
      && $stable(work_out)) else $error("or to file wrong");

   or_zero_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_or_work or s_or_file |=> zero_out == (($past(work_out) | $past(file_rdata_in)) == '0))
      else $error("or zero flag wrong");

   dest_file_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_move_file
      |=> file_we_out && file_waddr_out == $past(instr_in[oraex_pkg::ADDR_W-1:0])
      && file_wdata_out == $past(file_rdata_in) && $stable(work_out)) else $error("move to file wrong");

   move_work_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_move_work |=> work_out == $past(file_rdata_in) && !file_we_out) else $error("move to work wrong");

   move_zero_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_move_any |=> zero_out == ($past(file_rdata_in) == '0)) else $error("move zero flag wrong");

   literal_load_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_literal |=> work_out == $past(instr_in[oraex_pkg::DATA_W-1:0]) && $stable(zero_out) && !file_we_out)
      else $error("literal load wrong");

   store_work_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_store |=> file_we_out && file_wdata_out == $past(work_out) && $stable(zero_out) && $stable(work_out))
      else $error("store work wrong");

   store_addr_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_store |=> file_waddr_out == $past(instr_in[oraex_pkg::ADDR_W-1:0])) else $error("store address wrong");

   // words outside the four opcodes must leave work, zero, write address and write data alone, and clear handled and write enable
   refused_word_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      instr_valid_in && dec.op == oraex_pkg::oraex_op_none
      |=> !handled_out && !file_we_out && $stable(work_out) && $stable(zero_out))
      else $error("refused word changed state");

   sequence s_valid_op;
      instr_valid_in && dec.op != oraex_pkg::oraex_op_none;
   endsequence
   one_cycle_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_valid_op |=> handled_out) else $error("instruction not done in one cycle");

   no_spurious_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      !instr_valid_in |=> !handled_out && !file_we_out) else $error("spurious activity");
endmodule

/* File: bench/oraex_file_model.sv */
// file register model answering reads and taking write-backs
`timescale 1ns/1ps
module oraex_file_model (
   input wire logic core_clk_in,
   input wire logic [6:0] raddr_in,
   output logic [7:0] rdata_out,
   input wire logic we_in,
   input wire logic [6:0] waddr_in,
   input wire logic [7:0] wdata_in
);
   logic [7:0] mem [128];
   assign rdata_out = mem[raddr_in];
   always @(posedge core_clk_in)
   begin
      if (we_in)
         mem[waddr_in] <= wdata_in;
   end
endmodule

/* File: bench/test_or_and_move_instruction_exec.sv */
// testbench of the instruction executor
`timescale 1ns/1ps
module test_or_and_move_instruction_exec;
   logic clk = 1'b0, resetn = 1'b0, valid = 1'b0, we, zero, handled;
   logic [13:0] instr = 14'h0000;
   logic [7:0] rdata, wdata, work;
   logic [6:0] raddr, waddr;
   int errors = 0, check_count = 0;
   oraex_core i_oraex_core (.core_clk_in(clk), .resetn_in(resetn), .instr_valid_in(valid), .instr_in(instr),
      .file_rdata_in(rdata), .file_raddr_out(raddr), .file_we_out(we), .file_waddr_out(waddr),
      .file_wdata_out(wdata), .work_out(work), .zero_out(zero), .handled_out(handled));
   oraex_file_model i_oraex_file_model (.core_clk_in(clk), .raddr_in(raddr), .rdata_out(rdata),
      .we_in(we), .waddr_in(waddr), .wdata_in(wdata));
   initial
   begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one word presented, then outputs judged one cycle later
   task automatic step(input logic [13:0] w, input logic [7:0] ew, input logic ez, ewe, eh, input logic [7:0] ed);
      @(posedge clk);
      instr <= w;
      valid <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
      #1;
      chk(work, ew);
      chk(8'(zero), 8'(ez));
      chk(8'(we), 8'(ewe));
      chk(8'(handled), 8'(eh));
      if (ewe)
         chk(wdata, ed);
      if (ewe)
         chk(8'(waddr), 8'(w[6:0]));
   endtask
   task automatic t_literal_store;
      step(14'h3000, 8'h00, 1'b0, 1'b0, 1'b1, 8'h00);
      step(14'h0085, 8'h00, 1'b0, 1'b1, 1'b1, 8'h00);
      step(14'h3313, 8'h13, 1'b0, 1'b0, 1'b1, 8'h00);
      step(14'h0087, 8'h13, 1'b0, 1'b1, 1'b1, 8'h13);
      $display("test literal and store done");
   endtask
   task automatic t_or;
      step(14'h3000, 8'h00, 1'b0, 1'b0, 1'b1, 8'h00);
      step(14'h0405, 8'h00, 1'b1, 1'b0, 1'b1, 8'h00);
      step(14'h3091, 8'h91, 1'b1, 1'b0, 1'b1, 8'h00);
      step(14'h0407, 8'h93, 1'b0, 1'b0, 1'b1, 8'h00);
      step(14'h3091, 8'h91, 1'b0, 1'b0, 1'b1, 8'h00);
      step(14'h0487, 8'h91, 1'b0, 1'b1, 1'b1, 8'h93);
      $display("test or done");
   endtask
   task automatic t_move;
      step(14'h0885, 8'h91, 1'b1, 1'b1, 1'b1, 8'h00);
      step(14'h0807, 8'h93, 1'b0, 1'b0, 1'b1, 8'h00);
      step(14'h3E00, 8'h93, 1'b0, 1'b0, 1'b0, 8'h00);
      $display("test move done");
   endtask
   task automatic t_back;
      @(posedge clk);
      instr <= 14'h300F;
      valid <= 1'b1;
      @(posedge clk);
      instr <= 14'h0088;
      #1;
      chk(work, 8'h0F);
      @(posedge clk);
      valid <= 1'b0;
      #1;
      chk(wdata, 8'h0F);
      @(posedge clk);
      #1;
      chk(i_oraex_file_model.mem[8], 8'h0F);
      $display("test back to back done");
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_literal_store();
      t_or();
      t_move();
      t_back();
      report_and_stop();
   end
   initial
   begin
      repeat (2000) @(posedge clk);
      errors++;
      report_and_stop();
   end
endmodule
